// ===== verilog/tpp_timer.v
// 16-bit timer core: one-pulse and PWM modes, capture channels, low-power behaviour.
// Assumes synchronous inputs and byte-wide CPU access strobes from outside.
// Overview of operation
// [RL1] One-pulse mode only when select bit set
// [RL2] Trigger: capture, preset FFFC, pulse level, flag
// [RL3] Capture flag raises irq when enabled
// [RL4] Flag clears: status read, then low read
// [RL5] Compare-1 match ends pulse with after-level
// [RL6] One-pulse never sets match flag a
// [RL7] PWM select overrides one-pulse select
// [RL8] Pin a no capture; pin b captures (the code still captures on pin a outside PWM)
// [RL9] One-pulse: compare 2 flags, no waveform
// [RL10] PWM compare values load at period end
// [RL11] High byte write locks until low written
// [RL12] PWM compare logic always enabled
// [RL13] PWM pin follows level a, then b
// [RL14] PWM compare-2 match presets counter FFFC
// [RL15] PWM sets neither match flag
// [RL16] PWM compare-2 match sets capture flag a
// [RL17] Equal levels give constant pin level
// [RL18] Pulse width is compare2 minus compare1
// [RL19] Compare value equals ticks minus five
// [RL20] Wait mode: timer runs, irq wakes
// [RL21] Halt freezes counter and registers
// [RL22] Halt capture edge armed, captured on wake
// [RL23] Clock field selects divider or external
// [RL24] Pin enable gates timer output
// [RL25] Edge select: 0 falling, 1 rising
// [RL26] Counter increments per tick, wraps
`timescale 1ns/10ps
`default_nettype none
`include "tpp_defs.vh"

module tpp_timer
#(
   parameter EXT_CLK_PRESENT = 1
)
(
   input  wire        ref_clk_in,
   input  wire        rst_n_in,
   // Control bits
   input  wire        single_pulse_select_in,
   input  wire        pwm_select_in,
   input  wire [1:0]  clock_select_field_in,
   input  wire        output_pin_a_enable_in,
   input  wire        after_match_level_a_in,
   input  wire        after_match_level_b_in,
   input  wire        trigger_edge_select_a_in,
   input  wire        trigger_edge_select_b_in,
   input  wire        ext_edge_rise_in,
   input  wire        capture_irq_enable_in,
   input  wire        match_irq_enable_in,
   input  wire        global_irq_mask_in,
   input  wire        halt_mode_in,
   input  wire        halt_wake_irq_in,
   input  wire        gpio_level_a_in,
   // Pins
   input  wire        trigger_capture_pin_a_in,
   input  wire        trigger_capture_pin_b_in,
   input  wire        ext_clk_in,
   // CPU byte writes and reads
   input  wire [7:0]  cpu_wdata_in,
   input  wire        cmp1_high_wr_in,
   input  wire        cmp1_low_wr_in,
   input  wire        cmp2_high_wr_in,
   input  wire        cmp2_low_wr_in,
   input  wire        status_rd_in,
   input  wire        cap_a_low_acc_in,
   input  wire        cap_b_low_acc_in,
   input  wire        match_a_clr_in,
   input  wire        match_b_clr_in,
   // Outputs
   output reg  [15:0] counter_out,
   output reg  [15:0] captured_count_a_out,
   output reg  [15:0] captured_count_b_out,
   output reg  [15:0] compare_value_1_out,
   output reg  [15:0] compare_value_2_out,
   output reg         capture_flag_a_out,
   output reg         capture_flag_b_out,
   output reg         match_flag_a_out,
   output reg         match_flag_b_out,
   output reg         compare_output_pin_a_out,
   output reg         compare_output_pin_b_out,
   output wire        timer_irq_out
);

   // =====================================================
   // Internal state
   reg  [15:0] cmp1_hold_r;
   reg  [15:0] cmp2_hold_r;
   reg         cmp1_lock_r;
   reg         cmp2_lock_r;
   reg         cmp1_pend_r;
   reg         cmp2_pend_r;
   reg         cap_a_d_r;
   reg         cap_b_d_r;
   reg         arm_a_r;
   reg         arm_b_r;
   reg         rd_a_r;
   reg         rd_b_r;
   reg         halt_d_r;
   reg         wave_r;
   wire        tick;
   wire        pwm_on;
   wire        opm_on;
   wire        edge_a;
   wire        edge_b;
   wire        match1;
   wire        match2;
   wire        wake;
   wire        run;

   // Mode select: PWM wins over one-pulse
   assign pwm_on = pwm_select_in;                            // RL7
   assign opm_on = single_pulse_select_in & ~pwm_select_in;  // RL1

   // Halt freezes; wake by interrupt resumes from frozen count
   assign run  = ~halt_mode_in;                              // RL21
   assign wake = halt_d_r & ~halt_mode_in & halt_wake_irq_in;

   // Edge detection on capture pins
   assign edge_a = trigger_edge_select_a_in ? (trigger_capture_pin_a_in & ~cap_a_d_r)
                                            : (~trigger_capture_pin_a_in & cap_a_d_r); // RL25
   assign edge_b = trigger_edge_select_b_in ? (trigger_capture_pin_b_in & ~cap_b_d_r)
                                            : (~trigger_capture_pin_b_in & cap_b_d_r);

   // Compare matches on a tick against the active (shadow) values
   assign match1 = tick & (counter_out == compare_value_1_out); // RL12
   assign match2 = tick & (counter_out == compare_value_2_out);

   // Interrupt: capture and match flags gated by their enables and global mask
   assign timer_irq_out = ~global_irq_mask_in &
                          ((capture_irq_enable_in & (capture_flag_a_out | capture_flag_b_out)) |
                           (match_irq_enable_in & (match_flag_a_out | match_flag_b_out))); // RL3 RL16 RL20

   // =====================================================
   // Timer clock tick generator
   tpp_tick_gen i_tpp_tick_gen
   (
      .ref_clk_in            (ref_clk_in),
      .rst_n_in              (rst_n_in),
      .clock_select_field_in (clock_select_field_in), // RL23
      .ext_clk_in            (ext_clk_in),
      .ext_edge_rise_in      (ext_edge_rise_in),
      .ext_clk_present_in    (EXT_CLK_PRESENT != 0),
      .freeze_in             (~run),
      .tick_out              (tick)
   );

   // =====================================================
   // Counter: increment, wrap, preset on trigger or period end
   always @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         counter_out <= `TPP_CNT_RESET_VAL;
      else if (run)
      begin
         if (opm_on && edge_a)
            counter_out <= `TPP_PRESET_VAL;      // RL2
         else if (pwm_on && match2)
            counter_out <= `TPP_PRESET_VAL;      // RL14 RL19
         else if (tick)
            counter_out <= counter_out + 16'h0001; // RL26
      end
   end

   // =====================================================
   // Compare registers: byte writes, lock, shadow transfer
   always @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         cmp1_hold_r <= 16'hFFFF;
         cmp2_hold_r <= 16'hFFFF;
         cmp1_lock_r <= 1'b0;
         cmp2_lock_r <= 1'b0;
         cmp1_pend_r <= 1'b0;
         cmp2_pend_r <= 1'b0;
         compare_value_1_out <= 16'hFFFF;
         compare_value_2_out <= 16'hFFFF;
      end
      else if (run)
      begin
         if (cmp1_high_wr_in)
         begin
            cmp1_hold_r[15:8] <= cpu_wdata_in;
            cmp1_lock_r       <= 1'b1;             // RL11
         end
         if (cmp1_low_wr_in)
         begin
            cmp1_hold_r[7:0] <= cpu_wdata_in;
            cmp1_lock_r      <= 1'b0;
            cmp1_pend_r      <= 1'b1;
         end
         if (cmp2_high_wr_in)
         begin
            cmp2_hold_r[15:8] <= cpu_wdata_in;
            cmp2_lock_r       <= 1'b1;             // RL11
         end
         if (cmp2_low_wr_in)
         begin
            cmp2_hold_r[7:0] <= cpu_wdata_in;
            cmp2_lock_r      <= 1'b0;
            cmp2_pend_r      <= 1'b1;
         end
         // Transfer: outside PWM at once, in PWM only at period end
         if (cmp1_pend_r && !cmp1_lock_r && (!pwm_on || match2))
         begin
            compare_value_1_out <= cmp1_hold_r;  // RL10
            cmp1_pend_r         <= cmp1_low_wr_in;
         end
         if (cmp2_pend_r && !cmp2_lock_r && (!pwm_on || match2))
         begin
            compare_value_2_out <= cmp2_hold_r;  // RL10
            cmp2_pend_r         <= cmp2_low_wr_in;
         end
      end
   end

   // =====================================================
   // Capture channels, halt arming, flags
   always @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         cap_a_d_r            <= 1'b0;
         cap_b_d_r            <= 1'b0;
         arm_a_r              <= 1'b0;
         arm_b_r              <= 1'b0;
         rd_a_r               <= 1'b0;
         rd_b_r               <= 1'b0;
         halt_d_r             <= 1'b0;
         captured_count_a_out <= 16'h0000;
         captured_count_b_out <= 16'h0000;
         capture_flag_a_out   <= 1'b0;
         capture_flag_b_out   <= 1'b0;
         match_flag_a_out     <= 1'b0;
         match_flag_b_out     <= 1'b0;
      end
      else
      begin
         cap_a_d_r <= trigger_capture_pin_a_in;
         cap_b_d_r <= trigger_capture_pin_b_in;
         halt_d_r  <= halt_mode_in;
         if (!run)
         begin
            // Edges during halt only arm detection
            if (edge_a && !pwm_on)
               arm_a_r <= 1'b1;                  // RL22
            if (edge_b)
               arm_b_r <= 1'b1;                  // RL22
         end
         else
         begin
            // Two-step clear: arm on status read, clear on low-byte access
            if (status_rd_in && capture_flag_a_out)
               rd_a_r <= 1'b1;
            else if (cap_a_low_acc_in)
               rd_a_r <= 1'b0;
            if (status_rd_in && capture_flag_b_out)
               rd_b_r <= 1'b1;
            else if (cap_b_low_acc_in)
               rd_b_r <= 1'b0;
            if (cap_a_low_acc_in && rd_a_r)
               capture_flag_a_out <= 1'b0;       // RL4
            if (cap_b_low_acc_in && rd_b_r)
               capture_flag_b_out <= 1'b0;       // RL4
            // Channel a: trigger in one-pulse, plain capture in compare mode, period flag only in PWM (set wins)
            if ((edge_a && !pwm_on) || (wake && arm_a_r))
            begin
               captured_count_a_out <= counter_out; // RL2 RL22
               capture_flag_a_out   <= 1'b1;
               arm_a_r              <= 1'b0;
            end
            else if (pwm_on && match2)
               capture_flag_a_out <= 1'b1;       // RL16
            // Channel b captures in every mode
            if (edge_b || (wake && arm_b_r))
            begin
               captured_count_b_out <= counter_out; // RL8
               capture_flag_b_out   <= 1'b1;
               arm_b_r              <= 1'b0;
            end
            // Match flags: software clear, hardware set wins
            if (match_a_clr_in)
               match_flag_a_out <= 1'b0;
            if (match_b_clr_in)
               match_flag_b_out <= 1'b0;
            if (match1 && !pwm_on && !opm_on)
               match_flag_a_out <= 1'b1;         // RL6 RL15
            if (match2 && !pwm_on)
               match_flag_b_out <= 1'b1;         // RL9 RL15
         end
      end
   end

   // =====================================================
   // Waveform generation and pin muxing
   always @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         wave_r                   <= 1'b0;
         compare_output_pin_a_out <= 1'b0;
         compare_output_pin_b_out <= 1'b0;
      end
      else
      begin
         if (run)
         begin
            if (opm_on && edge_a)
               wave_r <= after_match_level_b_in;  // RL2
            else if (opm_on && match1)
               wave_r <= after_match_level_a_in;  // RL5 RL17
            else if (pwm_on && match2)
               wave_r <= after_match_level_b_in;  // RL13 RL18
            else if (pwm_on && match1)
               wave_r <= after_match_level_a_in;  // RL13
            else if (!pwm_on && !opm_on && match1)
               wave_r <= after_match_level_a_in;
            // Channel b waveform only in plain compare mode
            if (!pwm_on && !opm_on && match2)
               compare_output_pin_b_out <= after_match_level_b_in; // RL9
         end
         compare_output_pin_a_out <= output_pin_a_enable_in ? wave_r : gpio_level_a_in; // RL24
      end
   end

endmodule // tpp_timer
`default_nettype wire

// ===== common/tpp_defs.vh
// Constants for the one-pulse / PWM timer block.
// Assumes inclusion by bare name from design files.
`ifndef TPP_DEFS_VH
`define TPP_DEFS_VH

// =====================================================
// Counter presets and clock selection
`define TPP_PRESET_VAL      16'hFFFC
`define TPP_CNT_RESET_VAL   16'hFFFC
`define TPP_CC_DIV4         2'h0
`define TPP_CC_DIV2         2'h1
`define TPP_CC_DIV8         2'h2
`define TPP_CC_EXT          2'h3
`define TPP_DIV_W           3
`define TPP_TIME_OFFSET     5

`endif

// ===== verilog/tpp_tick_gen.v
// Timer tick divider: one-cycle enable pulse from prescaler or external clock edge.
// Assumes all inputs synchronous to the clock.
`timescale 1ns/10ps
`default_nettype none
`include "tpp_defs.vh"

module tpp_tick_gen
(
   input  wire       ref_clk_in,
   input  wire       rst_n_in,
   input  wire [1:0] clock_select_field_in,
   input  wire       ext_clk_in,
   input  wire       ext_edge_rise_in,
   input  wire       ext_clk_present_in,
   input  wire       freeze_in,
   output reg        tick_out
);

   reg [`TPP_DIV_W-1:0] div_r;
   reg                  ext_d_r;
   reg                  tick_nxt;
   wire                 ext_edge;

   // =====================================================
   // External clock edge detect
   assign ext_edge = ext_edge_rise_in ? (ext_clk_in & ~ext_d_r) : (~ext_clk_in & ext_d_r);

   // Select tick source
   always @*
   begin
      case (clock_select_field_in)
         `TPP_CC_DIV4: tick_nxt = (div_r[1:0] == 2'h3);
         `TPP_CC_DIV2: tick_nxt = div_r[0];
         `TPP_CC_DIV8: tick_nxt = (div_r == 3'h7);
         default:      tick_nxt = ext_clk_present_in & ext_edge; // Missing pin stops counting
      endcase
   end

   // Prescaler counter and registered tick
   always @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         div_r   <= 3'h0;
         ext_d_r <= 1'b0;
         tick_out <= 1'b0;
      end
      else
      begin
         ext_d_r <= ext_clk_in;
         if (freeze_in)
            tick_out <= 1'b0;
         else
         begin
            div_r    <= div_r + 3'h1;
            tick_out <= tick_nxt;
         end
      end
   end

endmodule // tpp_tick_gen
`default_nettype wire

// ===== dv/tpp_timer_assertions.sv
// Port-level properties of the one-pulse / PWM timer core.
// Assumes it is bound onto tpp_timer and sees only its ports.
`timescale 1ns/10ps
`default_nettype none

module tpp_timer_assertions
(
   input wire logic        ref_clk_in,
   input wire logic        rst_n_in,
   input wire logic        single_pulse_select_in,
   input wire logic        pwm_select_in,
   input wire logic        halt_mode_in,
   input wire logic        output_pin_a_enable_in,
   input wire logic        gpio_level_a_in,
   input wire logic        capture_irq_enable_in,
   input wire logic        global_irq_mask_in,
   input wire logic        cap_a_low_acc_in,
   input wire logic [15:0] counter_out,
   input wire logic [15:0] compare_value_2_out,
   input wire logic        capture_flag_a_out,
   input wire logic        match_flag_a_out,
   input wire logic        compare_output_pin_a_out,
   input wire logic        timer_irq_out
);
   // ==========================================
   // Properties, all in the core clock domain
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);

   AST_OPM_TRIGGER_PRESET:
      assert property ($rose(capture_flag_a_out) && $past(single_pulse_select_in)
         && !$past(pwm_select_in) |-> counter_out == 16'hFFFC)
      else $error("trigger did not preset the counter");
   AST_OPM_NO_MATCH_A:
      assert property ($past(single_pulse_select_in) && $past(single_pulse_select_in, 2)
         && !$past(pwm_select_in) && !$past(pwm_select_in, 2) |-> !$rose(match_flag_a_out))
      else $error("match flag a set in one-pulse mode");
   AST_PWM_NO_MATCH_A:
      assert property ($past(pwm_select_in) && $past(pwm_select_in, 2)
         |-> !$rose(match_flag_a_out))
      else $error("match flag a set in pwm mode");
   AST_PWM_PERIOD_END:
      assert property (pwm_select_in && !halt_mode_in && counter_out == compare_value_2_out
         |-> ##[1:40] counter_out == 16'hFFFC)
      else $error("period end did not preset the counter");
   AST_CAPTURE_IRQ:
      assert property (capture_flag_a_out && capture_irq_enable_in && !global_irq_mask_in
         |-> timer_irq_out)
      else $error("capture flag without interrupt");
   AST_FLAG_CLEAR_CAUSE:
      assert property ($fell(capture_flag_a_out) |-> $past(cap_a_low_acc_in))
      else $error("capture flag a cleared without low byte access");
   AST_HALT_FREEZE:
      assert property (halt_mode_in && $past(halt_mode_in) |-> $stable(counter_out))
      else $error("counter moved during halt");
   AST_COUNT_STEP:
      assert property ($changed(counter_out) |-> counter_out == 16'hFFFC
         || counter_out == $past(counter_out) + 16'h0001)
      else $error("counter jumped");
   AST_PIN_GPIO:
      assert property ($past(rst_n_in) && !$past(output_pin_a_enable_in) && !$past(halt_mode_in)
         |-> compare_output_pin_a_out == $past(gpio_level_a_in))
      else $error("disabled pin a does not follow gpio level");
endmodule // tpp_timer_assertions

bind tpp_timer tpp_timer_assertions i_tpp_timer_assertions
(
   .ref_clk_in, .rst_n_in, .single_pulse_select_in, .pwm_select_in, .halt_mode_in,
   .output_pin_a_enable_in, .gpio_level_a_in, .capture_irq_enable_in,
   .global_irq_mask_in, .cap_a_low_acc_in, .counter_out, .compare_value_2_out,
   .capture_flag_a_out, .match_flag_a_out, .compare_output_pin_a_out, .timer_irq_out
);
`default_nettype wire

// ===== dv/tpp_pin_partner.sv
// Far side of the timer pins: trigger sources and an external clock.
// Assumes one-cycle fire requests from the bench; clock stands low when off.
`timescale 1ns/10ps
`default_nettype none

module tpp_pin_partner
(
   input  wire logic clk_in,
   input  wire logic fire_a_in,
   input  wire logic fire_b_in,
   input  wire logic ext_run_in,
   output wire logic pin_a_out,
   output wire logic pin_b_out,
   output var logic  ext_clk_out
);
   logic [3:0] hold_a_r = 4'h0;
   logic [3:0] hold_b_r = 4'h0;
   logic [1:0] div_r    = 2'h0;

   // ==========================================
   // Pin pulses of 8 cycles, external clock of 6 cycles
   initial ext_clk_out = 1'b0;
   always @(posedge clk_in)
   begin
      hold_a_r <= fire_a_in ? 4'h8 : hold_a_r - {3'h0, hold_a_r != 4'h0};
      hold_b_r <= fire_b_in ? 4'h8 : hold_b_r - {3'h0, hold_b_r != 4'h0};
      div_r    <= (div_r == 2'h2 || !ext_run_in) ? 2'h0 : div_r + 2'h1;
      if (!ext_run_in)
         ext_clk_out <= 1'b0;
      else if (div_r == 2'h2)
         ext_clk_out <= !ext_clk_out;
   end
   assign pin_a_out = (hold_a_r != 4'h0);
   assign pin_b_out = (hold_b_r != 4'h0);
endmodule // tpp_pin_partner
`default_nettype wire

// ===== dv/tpp_timer_bench.sv
// Testbench of the timer core: one-pulse, PWM, capture, halt, clock select.
// Assumes tpp_timer, tpp_pin_partner and the bound checker are compiled.
`timescale 1ns/10ps
`default_nettype none

module tpp_timer_bench;
   logic ref_clk_in = 1'b0, rst_n_in = 1'b0, single_pulse_select_in = 1'b0;
   logic pwm_select_in = 1'b0, output_pin_a_enable_in = 1'b1, halt_mode_in = 1'b0;
   logic after_match_level_a_in = 1'b0, after_match_level_b_in = 1'b1;
   logic capture_irq_enable_in = 1'b1, match_irq_enable_in = 1'b0;
   logic global_irq_mask_in = 1'b0, gpio_level_a_in = 1'b0;
   logic [1:0] clock_select_field_in = 2'h1;
   logic [7:0] cpu_wdata_in = 8'h00;
   logic cmp1_high_wr_in = 1'b0, cmp1_low_wr_in = 1'b0, cmp2_high_wr_in = 1'b0;
   logic cmp2_low_wr_in = 1'b0, status_rd_in = 1'b0, cap_a_low_acc_in = 1'b0;
   logic match_a_clr_in = 1'b0, match_b_clr_in = 1'b0;
   logic fire_a = 1'b0, fire_b = 1'b0, ext_run = 1'b0, edge_a_sel = 1'b1;
   wire logic trigger_capture_pin_a_in, trigger_capture_pin_b_in, ext_clk_in;
   wire logic [15:0] counter_out, compare_value_1_out, compare_value_2_out, cap_a, cap_b;
   wire logic capture_flag_a_out, capture_flag_b_out, match_flag_a_out, match_flag_b_out;
   wire logic compare_output_pin_a_out, compare_output_pin_b_out, timer_irq_out;
   int num_errors = 0, compares = 0, n, w, l, p, seed;
   logic [15:0] c1, c2, v;

   // ==========================================
   // Design, pin partner and clock
   tpp_timer i_tpp_timer
   (
      .ref_clk_in, .rst_n_in, .single_pulse_select_in, .pwm_select_in,
      .clock_select_field_in, .output_pin_a_enable_in, .after_match_level_a_in,
      .after_match_level_b_in, .trigger_edge_select_a_in(edge_a_sel),
      .trigger_edge_select_b_in(1'b1), .ext_edge_rise_in(1'b1), .capture_irq_enable_in,
      .match_irq_enable_in, .global_irq_mask_in, .halt_mode_in, .halt_wake_irq_in(1'b1),
      .gpio_level_a_in, .trigger_capture_pin_a_in, .trigger_capture_pin_b_in, .ext_clk_in,
      .cpu_wdata_in, .cmp1_high_wr_in, .cmp1_low_wr_in, .cmp2_high_wr_in, .cmp2_low_wr_in,
      .status_rd_in, .cap_a_low_acc_in, .cap_b_low_acc_in(1'b0), .match_a_clr_in,
      .match_b_clr_in, .counter_out, .captured_count_a_out(cap_a), .captured_count_b_out(cap_b),
      .compare_value_1_out, .compare_value_2_out, .capture_flag_a_out, .capture_flag_b_out,
      .match_flag_a_out, .match_flag_b_out, .compare_output_pin_a_out,
      .compare_output_pin_b_out, .timer_irq_out
   );
   tpp_pin_partner i_tpp_pin_partner
   (
      .clk_in(ref_clk_in), .fire_a_in(fire_a), .fire_b_in(fire_b), .ext_run_in(ext_run),
      .pin_a_out(trigger_capture_pin_a_in), .pin_b_out(trigger_capture_pin_b_in),
      .ext_clk_out(ext_clk_in)
   );
   initial forever #2.5 ref_clk_in = ~ref_clk_in;

   // ==========================================
   // Compare, wait and drive helpers
   task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e)
      begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chkb(input string nm, input logic e, input logic g);
      compares++;
      if (g !== e)
      begin
         num_errors++;
         $display("unexpected %s: expected %b seen %b", nm, e, g);
      end
   endtask
   // Waits for pin a (s=0) or capture flag a (s=1) to reach a level
   task automatic wait_sig(input int s, input logic lvl, output int k);
      k = 0;
      while ((s ? capture_flag_a_out : compare_output_pin_a_out) !== lvl && k < 3000)
      begin
         @(posedge ref_clk_in);
         k++;
      end
      if (k >= 3000)
         chkb("wait level", lvl, ~lvl);
   endtask
   task automatic strobe(input int k);
      @(posedge ref_clk_in);
      case (k)
         0: status_rd_in <= 1'b1;
         1: cap_a_low_acc_in <= 1'b1;
         2: match_b_clr_in <= 1'b1;
         3: fire_a <= 1'b1;
         default: fire_b <= 1'b1;
      endcase
      @(posedge ref_clk_in);
      {status_rd_in, cap_a_low_acc_in, match_b_clr_in, fire_a, fire_b} <= 5'h00;
   endtask
   task automatic wr_byte(input logic two, input logic hi, input logic [7:0] b);
      @(posedge ref_clk_in);
      cpu_wdata_in <= b;
      {cmp1_high_wr_in, cmp2_high_wr_in} <= {!two && hi, two && hi};
      {cmp1_low_wr_in, cmp2_low_wr_in} <= {!two && !hi, two && !hi};
      @(posedge ref_clk_in);
      {cmp1_high_wr_in, cmp2_high_wr_in, cmp1_low_wr_in, cmp2_low_wr_in} <= 4'h0;
   endtask
   task automatic wr_cmp(input logic two, input logic [15:0] val);
      wr_byte(two, 1'b1, val[15:8]);
      wr_byte(two, 1'b0, val[7:0]);
   endtask
   task automatic do_reset;
      @(posedge ref_clk_in);
      rst_n_in <= 1'b0;
      repeat (10) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
   endtask
   task automatic finish_test;
      if (num_errors == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ==========================================
   // Watchdog
   initial
   begin
      #200000;
      num_errors++;
      finish_test();
   end

   // ==========================================
   // Scenarios
   initial
   begin
      seed = $urandom(31);
      single_pulse_select_in <= 1'b1;
      do_reset();
      chk16("counter", 16'hFFFC, counter_out);
      chk16("compare 1", 16'hFFFF, compare_value_1_out);
      wr_byte(1'b0, 1'b1, 8'h00);
      repeat (4) @(posedge ref_clk_in);
      chk16("compare 1 locked", 16'hFFFF, compare_value_1_out);
      wr_byte(1'b0, 1'b0, 8'h10);
      repeat (2) @(posedge ref_clk_in);
      chk16("compare 1", 16'h0010, compare_value_1_out);
      wr_cmp(1'b1, 16'h0004);
      // One pulse from a falling trigger edge, then flag handling
      edge_a_sel <= 1'b0;
      strobe(3);
      wait_sig(1, 1'b1, n);
      chkb("falling trigger", 1'b1, n >= 8 && n <= 12);
      wait_sig(0, 1'b1, n);
      wait_sig(0, 1'b0, w);
      chkb("pulse width", 1'b1, w >= 40 && w <= 44);
      chkb("match flag a", 1'b0, match_flag_a_out);
      chkb("match flag b", 1'b1, match_flag_b_out);
      chkb("pin b", 1'b0, compare_output_pin_b_out);
      strobe(1);
      repeat (2) @(posedge ref_clk_in);
      chkb("flag a kept", 1'b1, capture_flag_a_out);
      chkb("irq", 1'b1, timer_irq_out);
      global_irq_mask_in <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      chkb("irq masked", 1'b0, timer_irq_out);
      global_irq_mask_in <= 1'b0;
      strobe(0);
      strobe(1);
      repeat (2) @(posedge ref_clk_in);
      chkb("flag a cleared", 1'b0, capture_flag_a_out);
      match_irq_enable_in <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      chkb("match irq", 1'b1, timer_irq_out);
      strobe(2);
      repeat (2) @(posedge ref_clk_in);
      chkb("match flag b cleared", 1'b0, match_flag_b_out);
      strobe(4);
      repeat (6) @(posedge ref_clk_in);
      chkb("capture flag b", 1'b1, capture_flag_b_out);
      // Pin a as general purpose output
      output_pin_a_enable_in <= 1'b0;
      repeat (8) @(posedge ref_clk_in) gpio_level_a_in <= 1'($urandom);
      repeat (2) @(posedge ref_clk_in);
      chkb("gpio pin", gpio_level_a_in, compare_output_pin_a_out);
      output_pin_a_enable_in <= 1'b1;
      // PWM with both selects set, each prescaler, random compares
      for (int i = 0; i < 3; i++)
      begin
         c1 = 16'h0001 + 16'($urandom % 8);
         c2 = c1 + 16'h0008 + 16'($urandom % 8);
         p = (i == 0) ? 4 : (i == 1) ? 2 : 8;
         {pwm_select_in, after_match_level_a_in, after_match_level_b_in} <= 3'b110;
         clock_select_field_in <= i[1:0];
         do_reset();
         wr_cmp(1'b0, c1);
         wr_cmp(1'b1, c2);
         wait_sig(0, 1'b1, n);
         wait_sig(0, 1'b0, n);
         wait_sig(0, 1'b1, n);
         wait_sig(0, 1'b0, w);
         wait_sig(0, 1'b1, l);
         chkb("pwm high", 1'b1, w >= (c2 - c1 - 1) * p && w <= (c2 - c1 + 1) * p);
         chkb("pwm period", 1'b1, w + l >= (c2 + 4) * p && w + l <= (c2 + 6) * p);
         chkb("period flag", 1'b1, capture_flag_a_out);
         chkb("pwm match flag b", 1'b0, match_flag_b_out);
         wr_cmp(1'b1, c2 + 16'h0008);
         wr_byte(1'b1, 1'b1, 8'h00);
         chk16("shadow held", c2, compare_value_2_out);
         for (int j = 0; j < 2; j++)
         begin
            wait_sig(0, 1'b0, n);
            repeat (2) @(posedge ref_clk_in);
            chk16("shadow loaded", j ? c2 + 16'h0008 : c2, compare_value_2_out);
            wr_byte(1'b1, 1'b0, c2[7:0] + 8'h08);
            wait_sig(0, 1'b1, n);
         end
      end
      // External clock, halt freeze, stopped clock
      {pwm_select_in, single_pulse_select_in} <= 2'b00;
      clock_select_field_in <= 2'h3;
      do_reset();
      ext_run <= 1'b1;
      repeat (60) @(posedge ref_clk_in);
      v = counter_out - 16'hFFFC;
      chkb("ext count", 1'b1, v >= 16'h0008 && v <= 16'h000B);
      halt_mode_in <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      v = counter_out;
      strobe(3);
      strobe(4);
      repeat (20) @(posedge ref_clk_in);
      chk16("halted counter", v, counter_out);
      {halt_mode_in, ext_run} <= 2'b00;
      repeat (4) @(posedge ref_clk_in);
      chk16("wake capture a", v, cap_a);
      chk16("wake capture b", v, cap_b);
      v = counter_out;
      repeat (20) @(posedge ref_clk_in);
      chk16("stopped counter", v, counter_out);
      finish_test();
   end
endmodule // tpp_timer_bench
`default_nettype wire
